// ### pkg/dpcm_consts.svh
// Named offsets, field positions, reset values and map limits of the paged storage map
`ifndef DPCM_CONSTS_SVH
`define DPCM_CONSTS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define DPCM_IDX_PAGE_SEL 8'h00
`define DPCM_IDX_RSVD_LAST 8'h07
`define DPCM_IDX_CTRL 8'h80
`define DPCM_HADDR_IDX_MSB 9
`define DPCM_HADDR_IDX_LSB 2
`define DPCM_HADDR_TOP_LSB 10
`define DPCM_HADDR_HIGH_ZERO 22'h000000

// ------------------------------------------------------------
// Control register fields and reset values
// ------------------------------------------------------------
`define DPCM_CTRL_PROG_BIT 0
`define DPCM_CTRL_PWR_BIT 1
`define DPCM_CTRL_LOCK_BIT 2
`define DPCM_PAGE_RESET 8'h00
`define DPCM_PROG_RESET 1'b0
`define DPCM_WORD_ZERO 32'h00000000
`define DPCM_HTRANS_NONSEQ 2'h2
`define DPCM_HRESP_OKAY 1'b0

// ------------------------------------------------------------
// Paged map limits
// ------------------------------------------------------------
`define DPCM_INSTR_PAGE_FIRST 8'h98
`define DPCM_INSTR_PAGE_LAST 8'hBA
`define DPCM_INSTR_BYTES_PER_PAGE 13'h0078
`define DPCM_INSTR_BYTES 4200
`define DPCM_DATA_REG_FIRST 7'h08
`define DPCM_BANK_A_PAGE_FIRST 8'h08
`define DPCM_BANK_A_PAGE_LAST 8'h10
`define DPCM_BANK_B_PAGE_FIRST 8'h1A
`define DPCM_BANK_B_PAGE_LAST 8'h22
`define DPCM_SLOTS_PER_PAGE 9'h01E
`define DPCM_LAST_COEF 9'h0FF
`define DPCM_COEF_COUNT 256
`define DPCM_LANE_HI 2'h0
`define DPCM_LANE_MID 2'h1
`define DPCM_LANE_LO 2'h2
`define DPCM_LANE_RSVD 2'h3

`endif

// ### pkg/dpcm_pkg.sv
// Types shared by the paged storage map modules
package dpcm_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } dpcm_state_type;

  typedef struct packed {
    dpcm_state_type st;
    logic [7:0] page;
    logic [7:0] idx;
    logic mapped;
    logic wr;
    logic prog_en;
    logic ready;
    logic [31:0] rdata;
  } dpcm_regs_type;

endpackage : dpcm_pkg

// ### rtl/dpcm_decode.sv
// Page and register decode into instruction byte address or coefficient slot and lane
`timescale 1ns/10ps
`include "dpcm_consts.svh"

module dpcm_decode (
  input wire logic [7:0] page,
  input wire logic [6:0] reg_num,
  output logic instr_hit,
  output logic [12:0] instr_addr,
  output logic coef_hit,
  output logic bank_b,
  output logic [7:0] coef_idx,
  output logic [1:0] lane
);

  // ------------------------------------------------------------
  // Slot arithmetic shared by both banks
  // ------------------------------------------------------------
  function automatic logic [8:0] slot_of(input logic [7:0] pg, input logic [7:0] first, input logic [6:0] rg);
    logic [8:0] rel;
    rel = {1'b0, pg - first};
    slot_of = 9'(rel * `DPCM_SLOTS_PER_PAGE) + {4'h0, 5'(7'(rg - `DPCM_DATA_REG_FIRST) >> 2)};
  endfunction : slot_of

  logic data_reg;
  logic in_a;
  logic in_b;
  logic [8:0] slot;

  always_comb begin
    data_reg = reg_num >= `DPCM_DATA_REG_FIRST;
    instr_hit = data_reg && page >= `DPCM_INSTR_PAGE_FIRST && page <= `DPCM_INSTR_PAGE_LAST;
    instr_addr = 13'(13'(page - `DPCM_INSTR_PAGE_FIRST) * `DPCM_INSTR_BYTES_PER_PAGE)
      + {6'h00, 7'(reg_num - `DPCM_DATA_REG_FIRST)};
    in_a = page >= `DPCM_BANK_A_PAGE_FIRST && page <= `DPCM_BANK_A_PAGE_LAST;
    in_b = page >= `DPCM_BANK_B_PAGE_FIRST && page <= `DPCM_BANK_B_PAGE_LAST;
    bank_b = in_b;
    slot = in_b ? slot_of(page, `DPCM_BANK_B_PAGE_FIRST, reg_num) : slot_of(page, `DPCM_BANK_A_PAGE_FIRST, reg_num);
    lane = reg_num[1:0];
    coef_idx = slot[7:0];
    // Reserved lane and slots past the last coefficient are not storage
    coef_hit = data_reg && (in_a || in_b) && lane != `DPCM_LANE_RSVD && slot <= `DPCM_LAST_COEF;
  end

endmodule : dpcm_decode

// ### rtl/dpcm_top.sv
// AHB-Lite slave holding the paged instruction memory and record coefficient banks
`timescale 1ns/10ps
`include "dpcm_consts.svh"

// Function
// - Instruction window on pages 0x98-0xBA, regs 8-127
// - Instruction memory holds 24-bit program words
// - Instruction access blocked when programmable and powered
// - Bank A pages 8-16, four-register slots
// - Bank B pages 26-34, same slot layout
// - Slot lanes: high, middle, low, reserved
// - Register 0 selects page, resets zero
module dpcm_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic PLAYBACK_POWERED,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  output logic PROG_MODE_EN,
  output logic INSTR_LOCKED
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Program words are kept as their three byte registers each
  logic [7:0] instr_mem [0:`DPCM_INSTR_BYTES-1];
  logic [23:0] coef_a [0:`DPCM_COEF_COUNT-1];
  logic [23:0] coef_b [0:`DPCM_COEF_COUNT-1];

  dpcm_pkg::dpcm_regs_type r_q;
  dpcm_pkg::dpcm_regs_type r_d;
  logic locked_q;

  logic instr_hit;
  logic [12:0] instr_addr;
  logic coef_hit;
  logic bank_b;
  logic [7:0] coef_idx;
  logic [1:0] lane;
  logic take;
  logic lock_now;
  logic do_instr;
  logic do_coef;
  logic data_cycle;
  logic [23:0] coef_word;
  logic [7:0] coef_byte;
  logic [23:0] coef_new;

  // Decode runs on the page and index held for the access cycle
  dpcm_decode u_decode (
    .page(r_q.page),
    .reg_num(r_q.idx[6:0]),
    .instr_hit(instr_hit),
    .instr_addr(instr_addr),
    .coef_hit(coef_hit),
    .bank_b(bank_b),
    .coef_idx(coef_idx),
    .lane(lane)
  );

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // Only aligned addresses inside the decode window reach a register
  function automatic logic reg_hit(input logic mapped, input logic [7:0] idx, input logic [7:0] target);
    return mapped && idx == target;
  endfunction : reg_hit

  // Byte of a coefficient word seen through one lane
  function automatic logic [7:0] lane_pick(input logic [23:0] word, input logic [1:0] ln);
    logic [7:0] b;
    unique case (ln)
      `DPCM_LANE_HI: b = word[23:16];
      `DPCM_LANE_MID: b = word[15:8];
      default: b = word[7:0];
    endcase
    return b;
  endfunction : lane_pick

  // One lane replaced, the other two kept: a byte write must not
  // disturb its neighbours in the same coefficient
  function automatic logic [23:0] lane_put(input logic [23:0] word, input logic [1:0] ln, input logic [7:0] b);
    logic [23:0] w;
    w = word;
    unique case (ln)
      `DPCM_LANE_HI: w[23:16] = b;
      `DPCM_LANE_MID: w[15:8] = b;
      default: w[7:0] = b;
    endcase
    return w;
  endfunction : lane_put

  // Live status word of the control register
  function automatic logic [31:0] ctrl_word(input logic prog, input logic pwr, input logic lock);
    logic [31:0] w;
    w = `DPCM_WORD_ZERO;
    w[`DPCM_CTRL_PROG_BIT] = prog;
    w[`DPCM_CTRL_PWR_BIT] = pwr;
    w[`DPCM_CTRL_LOCK_BIT] = lock;
    return w;
  endfunction : ctrl_word

  // ------------------------------------------------------------
  // Access qualification
  // ------------------------------------------------------------
  // Lock is judged in the access cycle, so a power-up that lands
  // during the address phase still blocks the transfer in flight
  always_comb begin
    take = HSEL && HREADY && HTRANS == `DPCM_HTRANS_NONSEQ;
    lock_now = r_q.prog_en && PLAYBACK_POWERED;
    data_cycle = r_q.st == dpcm_pkg::ST_ACCESS && r_q.mapped && !r_q.idx[7];
    do_instr = data_cycle && instr_hit && !lock_now;
    do_coef = data_cycle && coef_hit;
    coef_word = bank_b ? coef_b[coef_idx] : coef_a[coef_idx];
    coef_byte = lane_pick(coef_word, lane);
    coef_new = lane_put(coef_word, lane, HWDATA[7:0]);
  end

  // ------------------------------------------------------------
  // Bus state machine: one wait state per transfer
  // ------------------------------------------------------------
  // The wait state puts every write ahead of a following read, so
  // read-after-write to the same byte never returns stale data.
  always_comb begin
    r_d = r_q;
    unique case (r_q.st)
      dpcm_pkg::ST_IDLE: begin
        if (take) begin
          r_d.st = dpcm_pkg::ST_ACCESS;
          r_d.idx = HADDR[`DPCM_HADDR_IDX_MSB:`DPCM_HADDR_IDX_LSB];
          // High or misaligned addresses complete but decode to nothing
          r_d.mapped = HADDR[31:`DPCM_HADDR_TOP_LSB] == `DPCM_HADDR_HIGH_ZERO && HADDR[1:0] == 2'h0;
          r_d.wr = HWRITE;
          r_d.ready = 1'b0;
        end
      end
      dpcm_pkg::ST_ACCESS: begin
        r_d.st = dpcm_pkg::ST_IDLE;
        r_d.ready = 1'b1;
        r_d.rdata = `DPCM_WORD_ZERO;
        if (reg_hit(r_q.mapped, r_q.idx, `DPCM_IDX_PAGE_SEL)) begin
          if (r_q.wr) begin
            r_d.page = HWDATA[7:0];
          end else begin
            r_d.rdata[7:0] = r_q.page;
          end
        end else if (reg_hit(r_q.mapped, r_q.idx, `DPCM_IDX_CTRL)) begin
          if (r_q.wr) begin
            r_d.prog_en = HWDATA[`DPCM_CTRL_PROG_BIT];
          end else begin
            r_d.rdata = ctrl_word(r_q.prog_en, PLAYBACK_POWERED, lock_now);
          end
        end else if (!r_q.wr && do_instr) begin
          r_d.rdata[7:0] = instr_mem[instr_addr];
        end else if (!r_q.wr && do_coef) begin
          r_d.rdata[7:0] = coef_byte;
        end
      end
      default: begin
        r_d.st = dpcm_pkg::ST_IDLE;
        r_d.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_q.st <= dpcm_pkg::ST_IDLE;
      r_q.page <= `DPCM_PAGE_RESET;
      r_q.idx <= `DPCM_IDX_PAGE_SEL;
      r_q.mapped <= 1'b0;
      r_q.wr <= 1'b0;
      r_q.prog_en <= `DPCM_PROG_RESET;
      r_q.ready <= 1'b1;
      r_q.rdata <= `DPCM_WORD_ZERO;
      locked_q <= 1'b0;
    end else begin
      r_q <= r_d;
      locked_q <= lock_now;
    end
  end

  // ------------------------------------------------------------
  // Instruction memory, no reset: contents are undefined until loaded
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (do_instr && r_q.wr) begin
      instr_mem[instr_addr] <= HWDATA[7:0];
    end
  end

  // ------------------------------------------------------------
  // Coefficient banks, no reset
  // ------------------------------------------------------------
  // Whole-word read-modify-write inside the single access cycle
  always_ff @(posedge CLK) begin
    if (do_coef && r_q.wr && !bank_b) begin
      coef_a[coef_idx] <= coef_new;
    end
    if (do_coef && r_q.wr && bank_b) begin
      coef_b[coef_idx] <= coef_new;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_comb begin
    HREADYOUT = r_q.ready;
    // No error responses: every access ends OKAY
    HRESP = `DPCM_HRESP_OKAY;
    HRDATA = r_q.rdata;
    PROG_MODE_EN = r_q.prog_en;
    INSTR_LOCKED = locked_q;
  end

endmodule : dpcm_top

// ### testbench/dpcm_sva.sv
// Bus timing and lock checks on the storage map ports
`timescale 1ns/10ps
module dpcm_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HREADY,
  input wire logic PLAYBACK_POWERED,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  input wire logic PROG_MODE_EN,
  input wire logic INSTR_LOCKED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic tk;
  logic en;
  assign tk = HSEL && HREADY && (HTRANS == 2'h2) && HREADYOUT;
  assign en = PROG_MODE_EN & PLAYBACK_POWERED;
  property p_okay; HRESP == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("resp not okay");
  property p_wait; tk |=> !HREADYOUT ##1 HREADYOUT; endproperty
  a_wait: assert property (p_wait) else $error("no single wait");
  property p_one; !HREADYOUT |=> HREADYOUT; endproperty
  a_one: assert property (p_one) else $error("wait too long");
  property p_idle; HREADYOUT && !tk |=> HREADYOUT; endproperty
  a_idle: assert property (p_idle) else $error("stall when idle");
  property p_byte; HRDATA[31:8] == 24'h000000; endproperty
  a_byte: assert property (p_byte) else $error("upper read bits set");
  property p_hold; HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_prog; $changed(PROG_MODE_EN) |-> !$past(HREADYOUT); endproperty
  a_prog: assert property (p_prog) else $error("mode changed without write");
  property p_lock; INSTR_LOCKED == $past(en); endproperty
  a_lock: assert property (p_lock) else $error("lock wrong");
endmodule : dpcm_sva

// ### testbench/dpcm_host.sv
// Bus master model issuing single word transfers
`timescale 1ns/10ps
module dpcm_host (
  input wire logic CLK,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  output logic HSEL,
  output logic [31:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [2:0] HSIZE,
  output logic [31:0] HWDATA
);
  initial begin
    {HSEL, HADDR, HTRANS, HWRITE, HWDATA} <= '0;
    HSIZE <= 3'h2;
  end
  // Each phase is held until ready is seen high at an edge
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {22'h000000, idx, 2'h0};
    HWRITE <= wr;
    do @(posedge CLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask : xfer
endmodule : dpcm_host

// ### testbench/dpcm_top_tb.sv
// Self-checking bench of the paged storage map
`timescale 1ns/10ps
module dpcm_top_tb;
  logic clk, rst_n, pwr, hsel, hwrite, hready, hresp, prog, lock;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int bad_count, tests_run, cyc;
  // Page, base register, kind: 0 slot, 1 instruction, 2 dead
  logic [7:0] pg [10] = '{8'h08, 8'h10, 8'h1A, 8'h22, 8'h10, 8'h98, 8'hBA, 8'hBB, 8'h07, 8'h08};
  logic [7:0] rg [10] = '{8'h08, 8'h44, 8'h08, 8'h44, 8'h48, 8'h08, 8'h7C, 8'h08, 8'h08, 8'h01};
  int kd [10] = '{0, 0, 0, 0, 2, 1, 1, 2, 2, 2};
  dpcm_host host (.CLK(clk), .HREADY(hready), .HRDATA(hrdata), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata));
  dpcm_top dut (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .PLAYBACK_POWERED(pwr), .HREADYOUT(hready),
    .HRESP(hresp), .HRDATA(hrdata), .PROG_MODE_EN(prog), .INSTR_LOCKED(lock));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    host.xfer(1'b1, idx, d, rd);
  endtask : wr
  task automatic rc(input string nm, input logic [7:0] idx, input logic [31:0] e);
    host.xfer(1'b0, idx, 32'h00000000, rd);
    check(nm, rd, e);
  endtask : rc
  // Reserved lane and dead places read zero
  function automatic logic [31:0] ex(int i, int k);
    if (kd[i] == 2 || (kd[i] == 0 && k == 3)) return 32'h00000000;
    return 32'(i * 16 + k + 1);
  endfunction : ex
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    pwr = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rc("page", 8'h00, 32'h00000000);
    wr(8'h00, 32'h000000FF);
    rc("page", 8'h00, 32'h000000FF);
    for (int i = 0; i < 10; i++) begin
      wr(8'h00, 32'(pg[i]));
      for (int k = 0; k < 4; k++) wr(8'(rg[i] + k), 32'(i * 16 + k + 1));
    end
    // Read after all writes so aliasing between banks shows
    for (int i = 0; i < 10; i++) begin
      wr(8'h00, 32'(pg[i]));
      for (int k = 0; k < 4; k++) rc("map", 8'(rg[i] + k), ex(i, k));
    end
    wr(8'h80, 32'h00000001);
    check("prog", 32'(prog), 32'h00000001);
    pwr <= 1'b1;
    repeat (2) @(posedge clk);
    check("lock", 32'(lock), 32'h00000001);
    rc("ctrl", 8'h80, 32'h00000007);
    wr(8'h00, 32'h00000098);
    rc("blocked", 8'h08, 32'h00000000);
    wr(8'h08, 32'h000000EE);
    pwr <= 1'b0;
    repeat (2) @(posedge clk);
    rc("ctrl", 8'h80, 32'h00000001);
    rc("kept", 8'h08, ex(5, 0));
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check("prog", 32'(prog), 32'h00000000);
    rc("page", 8'h00, 32'h00000000);
    print_verdict();
  end
endmodule : dpcm_top_tb
bind dpcm_top dpcm_sva u_sva (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HTRANS(HTRANS), .HREADY(HREADY),
  .PLAYBACK_POWERED(PLAYBACK_POWERED), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
  .PROG_MODE_EN(PROG_MODE_EN), .INSTR_LOCKED(INSTR_LOCKED));
